// ### sim/dfbu_regfile_model.sv
// dfbu_regfile_model: registers 1 and 2 of the scalar register file.
// assumes the unit writes register 1 on ret_wr and reads register 2 steadily.
`timescale 1ns/1ps
`default_nettype none
module dfbu_regfile_model #(
  parameter logic [47:0] ENTRY = 48'h0000_0040_1000  // handler entry, plain value
) (
  input  wire logic        sys_clk,    // core clock
  input  wire logic        rst_n,      // synchronous reset, low active
  input  wire logic        ret_wr,     // register 1 write strobe
  input  wire logic [47:0] ret_addr,   // return address
  output logic      [47:0] entry_addr, // register 2 contents
  output logic      [47:0] reg1_q      // register 1 contents
);
  // register 2 is kept for the handler entry only, so it never moves
  assign entry_addr = ENTRY;
  // register 1 only ever takes the return address of a flag branch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) reg1_q <= 48'h0;
    else if (ret_wr) reg1_q <= ret_addr;
  end
endmodule
`default_nettype wire

// ### sim/dfbu_unit_bench.sv
// dfbu_unit_bench: directed instruction sequences against the flag branch unit.
// assumes one-cycle strobes and a branch answer one cycle after inst_end.
`timescale 1ns/1ps
`default_nettype none
module dfbu_unit_bench import dfbu_pkg::*;;
  localparam logic [47:0] ENT = 48'h0000_0040_1000;  // handler entry in register 2
  localparam logic [47:0] NXT = 48'h0000_1234_5678;  // return address offered
  localparam logic [63:0] ALL = 64'hffff_ffff_ffff_ffff;
  logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic        inst_start = 1'b0, inst_end = 1'b0, inst_noop = 1'b0;
  logic [7:0]  inst_op = 8'h00;
  logic [47:0] next_addr = NXT, entry_addr, reg1_q, ret_addr, fetch_addr;
  logic [12:0] cond_event = 13'h0, mask_wdata = 13'h0, flag_clr = 13'h0;
  logic        cond_permit = 1'b1, search_nomatch = 1'b0, timer_event = 1'b0;
  logic [2:0]  free_may_set = 3'h0, free_event = 3'h0;
  logic        mask_wr = 1'b0, ldst_wr = 1'b0, ret_wr, fetch_redirect;
  logic [63:0] ldst_wdata = 64'h0, flag_branch_reg;
  int          mismatches = 0, checks = 0, cyc = 0;
  logic [7:0]  srch [3] = '{DFBU_OP_SRCHW, DFBU_OP_SRCHB, DFBU_OP_SRCHT};

  dfbu_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .inst_start(inst_start), .inst_end(inst_end), .inst_op(inst_op),
    .inst_noop(inst_noop), .next_addr(next_addr), .entry_addr(entry_addr),
    .cond_event(cond_event), .cond_permit(cond_permit), .search_nomatch(search_nomatch),
    .timer_event(timer_event), .free_may_set(free_may_set), .free_event(free_event),
    .mask_wr(mask_wr), .mask_wdata(mask_wdata), .ldst_wr(ldst_wr),
    .ldst_wdata(ldst_wdata), .flag_clr(flag_clr), .flag_branch_reg(flag_branch_reg),
    .ret_wr(ret_wr), .ret_addr(ret_addr), .fetch_redirect(fetch_redirect),
    .fetch_addr(fetch_addr));
  dfbu_regfile_model #(.ENTRY(ENT)) regs (.sys_clk(sys_clk), .rst_n(rst_n),
    .ret_wr(ret_wr), .ret_addr(ret_addr), .entry_addr(entry_addr), .reg1_q(reg1_q));

  // free-running clock, 10 ns period
  always #5 sys_clk = ~sys_clk;
  // hang guard: the sequence needs well under a hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      summarize();
    end
  end
  // verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // register image under a mask against the expected bits
  task automatic chk_img(input logic [63:0] m, input logic [63:0] e);
    checks++;
    if ((flag_branch_reg & m) !== e) begin
      mismatches++;
      $display("Error %0t image %h want %h", $time, flag_branch_reg, e);
    end
  endtask
  // strobes and addresses
  task automatic chk_val(input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t output %h want %h", $time, g, e);
    end
  endtask
  // inputs change 1 ns after the edge so sampling never races
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // one instruction completion; its qualifiers are dropped afterwards
  task automatic ins(input logic [7:0] op);
    inst_op = op;
    inst_end = 1'b1;
    tick();
    inst_end = 1'b0;
    {mask_wr, ldst_wr, flag_clr, search_nomatch} = '0;
  endtask
  // one cycle of pipeline condition pulses
  task automatic ev(input logic [12:0] e, input logic p);
    cond_event = e;
    cond_permit = p;
    tick();
    cond_event = 13'h0;
    cond_permit = 1'b1;
  endtask
  // initial phase of an instruction that may set free flags
  task automatic start(input logic noop, input logic [2:0] may);
    {inst_start, inst_noop, free_may_set} = {1'b1, noop, may};
    tick();
    {inst_start, inst_noop, free_may_set} = '0;
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    chk_img(ALL, 64'h0);
    ev(13'h0001, 1'b1);
    chk_img(ALL, 64'h1 << 35);
    ev(13'h0010, 1'b0);
    chk_img(ALL, 64'h1 << 35);
    // wrong opcode: clear and mask data must be ignored
    {flag_clr, mask_wr, mask_wdata} = {13'h1fff, 1'b1, 13'h1fff};
    ins(8'h00);
    chk_img(ALL, 64'h1 << 35);
    {mask_wr, mask_wdata} = {1'b1, 13'h0001};
    ins(DFBU_OP_MASK);
    chk_img(ALL, 64'h0008_0008_0008_0008);
    chk_val(ret_wr, 1'b0);
    // full load: flag 47, masks 19 and 31, enable up
    {ldst_wr, ldst_wdata} = {1'b1, 64'h0010_8000_8008_0000};
    ins(DFBU_OP_LDST);
    chk_img(ALL, 64'h0018_8000_8008_8000);
    chk_val(ret_wr, 1'b0);
    ins(8'h00);
    chk_val({ret_wr, fetch_redirect}, 2'b11);
    chk_val(fetch_addr, ENT);
    chk_val(ret_addr, NXT);
    chk_img(64'h0018_0000_0000_0000, 64'h0008_0000_0000_0000);
    ins(8'h00);
    chk_val({ret_wr, reg1_q}, {1'b0, NXT});
    flag_clr = 13'h1000;
    ins(DFBU_OP_BRALT);
    chk_img(ALL, 64'h0010_0000_8008_0000);
    // first search misses, later hits must not clear the flag
    foreach (srch[i]) begin
      search_nomatch = (i == 0);
      ins(srch[i]);
      chk_img(64'h0000_0120_0000_0000, 64'h0000_0120_0000_0000);
    end
    {mask_wr, mask_wdata} = {1'b1, 13'h0020};
    ins(DFBU_OP_MASK);
    chk_img(64'h0008_0000_0100_0100, 64'h0008_0000_0100_0100);
    ins(8'h00);
    chk_val(ret_wr, 1'b1);
    timer_event = 1'b1;
    tick();
    timer_event = 1'b0;
    chk_img(64'h1 << 36, 64'h1 << 36);
    flag_clr = 13'h1fff;
    ins(DFBU_OP_BRALT);
    free_event = 3'h5;
    tick();
    free_event = 3'h0;
    chk_img(64'h00f8_0000_0000_fff8, 64'h00b0_0000_0000_0000);
    ins(8'h00);
    chk_val(ret_wr, 1'b0);
    start(1'b1, 3'h7);
    chk_img(64'h00e0_0000_0000_0000, 64'h00a0_0000_0000_0000);
    start(1'b0, 3'h1);
    chk_img(64'h00e0_0000_0000_0000, 64'h0080_0000_0000_0000);
    // frozen clock enable: an event must not land
    clk_en = 1'b0;
    ev(13'h0001, 1'b1);
    clk_en = 1'b1;
    chk_img(64'h1 << 35, 64'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ### src/dfbu_pkg.sv
// dfbu_pkg: field layout, opcodes and reset values of the flag branch register.
// assumes a 64-bit register with flags, masks, products and control bits.
package dfbu_pkg;
  localparam int unsigned        DFBU_W        = 64;  // register width
  localparam int unsigned        DFBU_NCOND    = 13;  // masked condition flags
  localparam int unsigned        DFBU_PROD_LO  = 3;   // product field 3..15
  localparam int unsigned        DFBU_MASK_LO  = 19;  // mask field 19..31
  localparam int unsigned        DFBU_FLAG_LO  = 35;  // flag field 35..47
  localparam int unsigned        DFBU_OR_BIT   = 51;  // or of products
  localparam int unsigned        DFBU_EN_BIT   = 52;  // branch enable
  localparam int unsigned        DFBU_FREE_LO  = 53;  // free flags 53..55
  localparam int unsigned        DFBU_NFREE    = 3;   // number of free flags
  localparam int unsigned        DFBU_TIMER_IX = 1;   // flag 36 = timer
  localparam int unsigned        DFBU_NOMATCH_IX = 2; // flag 37
  localparam int unsigned        DFBU_SUM_IX   = 5;   // flag 40 = or of 37..39
  localparam int unsigned        DFBU_ADDR_W   = 48;  // address portion width
  localparam logic [7:0]         DFBU_OP_BRALT = 8'h32; // bit branch and alter
  localparam logic [7:0]         DFBU_OP_MASK  = 8'h33; // mask load
  localparam logic [7:0]         DFBU_OP_LDST  = 8'h3b; // register load/store
  localparam logic [7:0]         DFBU_OP_SRCHW = 8'hff; // search word
  localparam logic [7:0]         DFBU_OP_SRCHB = 8'hfe; // search byte
  localparam logic [7:0]         DFBU_OP_SRCHT = 8'hd6; // search bit
  localparam logic [12:0]        DFBU_FLAG_RST = 13'h0000; // flags after reset
  localparam logic [12:0]        DFBU_MASK_RST = 13'h0000; // masks after reset
  localparam logic               DFBU_EN_RST   = 1'b0;     // enable after reset
  localparam int unsigned        DFBU_LAG_LONG = 43;  // pipe 2 latency in instructions
  localparam int unsigned        DFBU_LAG_SHORT = 5;  // other register instructions
  typedef enum logic [1:0] {
    DFBU_RUN  = 2'b00,  // normal execution
    DFBU_SAVE = 2'b01,  // return address being written
    DFBU_JUMP = 2'b10   // handler fetch issued
  } dfbu_state_t;
endpackage

// ### src/dfbu_prod.sv
// dfbu_prod: combinational product field and its or, from flags and masks.
// assumes flag and mask vectors from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dfbu_prod #(
  parameter int unsigned N = 13  // number of masked conditions
) (
  input  wire logic [N-1:0] flags,    // sticky condition flags
  input  wire logic [N-1:0] masks,    // mask bits
  output logic      [N-1:0] products, // flag and mask
  output logic              any_prod  // or of all products
);
  // products are not stored, so they follow either order of setting
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_prod
      assign products[g] = flags[g] & masks[g];  // [RQ10] [RQ23]
    end
  endgenerate
  assign any_prod = |products;  // [RQ11]
endmodule
`default_nettype wire

// ### src/dfbu_unit.sv
// dfbu_unit: flag branch register and automatic branch sequencing.
// assumes issue logic gives opcode strobes and pipelines give condition events.
`timescale 1ns/1ps
`default_nettype none
//Contract
//RQ1: finish instruction, save next address, fetch handler
//RQ2: 64-bit register with separate fields
//RQ3: bits 35..47 are sticky condition flags
//RQ4: search no-match sets flag 37, match keeps
//RQ5: flags cleared only by 32 or 3b
//RQ6: non-permissive control vector element sets nothing
//RQ7: bits 19..31 are per-flag mask bits
//RQ8: masks written only by 33 or 3b
//RQ9: flag sets regardless of its mask
//RQ10: bits 3..15 equal flag and mask
//RQ11: bit 51 ors products, not clearable
//RQ12: branch at instruction end when 51 and 52
//RQ13: taking branch clears enable bit 52
//RQ14: 32 or 3b restores enable bit
//RQ15: flag 36 driven by interval timer
//RQ16: bits 53..55 free flags, no mask
//RQ17: free flag cleared at start, except no-op
//RQ18: free flags never trigger branch
//RQ19: software samples free flags before clearing
//RQ20: flag may come 43 or 5 instructions early
//RQ21: program reserves registers 1 and 2
//RQ22: flag 40 is or of 37..39
//RQ23: products computed combinationally, never stored
module dfbu_unit
  import dfbu_pkg::*;
#(
  parameter int unsigned ADDR_W = DFBU_ADDR_W  // instruction address width
) (
  input  wire logic              sys_clk,       // 100 MHz clock
  input  wire logic              rst_n,         // synchronous reset, low active
  input  wire logic              clk_en,        // freezes all state when low
  input  wire logic              inst_start,    // initial phase of an instruction
  input  wire logic              inst_end,      // current instruction completes
  input  wire logic [7:0]        inst_op,       // opcode, valid with start and end
  input  wire logic              inst_noop,     // instruction is a no-op
  input  wire logic [ADDR_W-1:0] next_addr,     // next sequential address
  input  wire logic [ADDR_W-1:0] entry_addr,    // register 2 contents
  input  wire logic [12:0]       cond_event,    // condition pulses from pipes
  input  wire logic              cond_permit,   // control vector bit permissive
  input  wire logic              search_nomatch,// search ended without match
  input  wire logic              timer_event,   // job interval timer expired
  input  wire logic [2:0]        free_may_set,  // free flags this instruction can set
  input  wire logic [2:0]        free_event,    // free flag set pulses
  input  wire logic              mask_wr,       // mask field write data valid
  input  wire logic [12:0]       mask_wdata,    // new mask field
  input  wire logic              ldst_wr,       // load/store write data valid
  input  wire logic [63:0]       ldst_wdata,    // new register image
  input  wire logic [12:0]       flag_clr,      // bits cleared by branch-and-alter
  output logic      [63:0]       flag_branch_reg, // register image
  output logic                   ret_wr,        // write register 1 address
  output logic      [ADDR_W-1:0] ret_addr,      // return address value
  output logic                   fetch_redirect,// fetch from handler
  output logic      [ADDR_W-1:0] fetch_addr     // handler entry address
);
  // entire state in one struct
  typedef struct packed {
    logic [12:0]       flags;   // sticky condition flags
    logic [12:0]       masks;   // mask bits
    logic              en;      // branch enable
    logic [2:0]        free;    // free flags
    logic              ret_wr;  // return write pulse
    logic [ADDR_W-1:0] ret;     // return address
    logic              redir;   // fetch redirect pulse
    logic [ADDR_W-1:0] tgt;     // handler address
  } dfbu_st_t;

  dfbu_st_t st_q;  // registered state
  dfbu_st_t st_d;  // next state

  logic [12:0] products;  // product field
  logic        any_prod;  // or of products
  logic [12:0] flags_eff; // flags with derived flag 40
  logic [12:0] ev;        // accepted events
  logic        is_alter;  // 32 or 3b at completion
  logic        take;      // branch taken now

  function automatic logic is_search(input logic [7:0] op);
    // the three masked-key search opcodes
    is_search = (op == DFBU_OP_SRCHW) || (op == DFBU_OP_SRCHB) || (op == DFBU_OP_SRCHT);
  endfunction

  // flag 40 follows 37..39 instead of being stored
  always_comb begin
    flags_eff = st_q.flags;
    flags_eff[DFBU_SUM_IX] = |st_q.flags[DFBU_SUM_IX-1:DFBU_NOMATCH_IX];  // [RQ22]
  end

  dfbu_prod #(
    .N (DFBU_NCOND)
  ) u_prod (
    .flags    (flags_eff),
    .masks    (st_q.masks),
    .products (products),
    .any_prod (any_prod)
  );

  // branch fires at instruction end; free flags take no part
  assign take = inst_end && any_prod && st_q.en;  // [RQ12] [RQ18]
  assign is_alter = inst_end && ((inst_op == DFBU_OP_BRALT) || (inst_op == DFBU_OP_LDST));

  // event gathering
  always_comb begin
    ev = cond_permit ? cond_event : 13'h0000;  // [RQ6]
    ev[DFBU_TIMER_IX] = timer_event;  // [RQ15]
    ev[DFBU_SUM_IX] = 1'b0;  // derived, events never set it
    if (inst_end && is_search(inst_op) && search_nomatch && cond_permit) begin
      ev[DFBU_NOMATCH_IX] = 1'b1;  // [RQ4]
    end
  end

  // next state
  always_comb begin
    st_d = st_q;
    st_d.ret_wr = 1'b0;
    st_d.redir = 1'b0;
    // flags are cleared only by the two alter opcodes, sets win over clears
    if (inst_end && inst_op == DFBU_OP_BRALT) begin
      st_d.flags = st_q.flags & ~flag_clr;  // [RQ5]
    end else if (inst_end && inst_op == DFBU_OP_LDST && ldst_wr) begin
      st_d.flags = ldst_wdata[DFBU_FLAG_LO +: DFBU_NCOND];  // [RQ5]
    end
    st_d.flags = st_d.flags | ev;  // [RQ3] [RQ9]
    // mask field only through 33 or 3b
    if (inst_end && inst_op == DFBU_OP_MASK && mask_wr) begin
      st_d.masks = mask_wdata;  // [RQ8]
    end else if (inst_end && inst_op == DFBU_OP_LDST && ldst_wr) begin
      st_d.masks = ldst_wdata[DFBU_MASK_LO +: DFBU_NCOND];  // [RQ8]
    end
    // enable re-armed by alter opcodes, cleared by a taken branch
    if (is_alter) begin
      st_d.en = 1'b1;  // [RQ14]
    end
    if (take) begin
      st_d.en = 1'b0;  // [RQ13]
      st_d.ret_wr = 1'b1;  // [RQ1]
      st_d.ret = next_addr;
      st_d.redir = 1'b1;
      st_d.tgt = entry_addr;
    end
    // free flags: cleared at start unless no-op, set by events
    if (inst_start && !inst_noop) begin
      st_d.free = st_q.free & ~free_may_set;  // [RQ17]
    end
    st_d.free = st_d.free | free_event;  // [RQ16]
  end

  // state register with clock enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.flags <= DFBU_FLAG_RST;
      st_q.masks <= DFBU_MASK_RST;
      st_q.en <= DFBU_EN_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // register image; the 43/5 instruction lag lives in the pipelines
  always_comb begin
    flag_branch_reg = 64'h0;  // [RQ2] [RQ20]
    flag_branch_reg[DFBU_FLAG_LO +: DFBU_NCOND] = flags_eff;
    flag_branch_reg[DFBU_MASK_LO +: DFBU_NCOND] = st_q.masks;
    flag_branch_reg[DFBU_PROD_LO +: DFBU_NCOND] = products;
    flag_branch_reg[DFBU_OR_BIT] = any_prod;
    flag_branch_reg[DFBU_EN_BIT] = st_q.en;
    flag_branch_reg[DFBU_FREE_LO +: DFBU_NFREE] = st_q.free;
  end

  assign ret_wr = st_q.ret_wr;
  assign ret_addr = st_q.ret;
  assign fetch_redirect = st_q.redir;
  assign fetch_addr = st_q.tgt;

  chk_branch_clears_en: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ13]
    clk_en && take |=> !st_q.en) else $error("enable not cleared by branch");
  chk_branch_saves_ret: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ1]
    clk_en && take |=> ret_wr && fetch_redirect && ret_addr == $past(next_addr))
    else $error("branch did not save return address");
  chk_prod_relation: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ10]
    flag_branch_reg[15:3] == (flag_branch_reg[47:35] & flag_branch_reg[31:19]))
    else $error("product field mismatch");
  chk_or_products: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ11]
    flag_branch_reg[51] == |flag_branch_reg[15:3]) else $error("or bit wrong");
  chk_flag_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ5]
    clk_en && !(inst_end && (inst_op == DFBU_OP_BRALT || inst_op == DFBU_OP_LDST))
    |=> (st_q.flags & $past(st_q.flags)) == $past(st_q.flags))
    else $error("flag lost without alter");
  chk_event_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ9]
    clk_en && cond_permit && cond_event[0] |=> st_q.flags[0]) else $error("event lost");
  chk_mask_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ8]
    clk_en && !(inst_end && (inst_op == DFBU_OP_MASK || inst_op == DFBU_OP_LDST))
    |=> $stable(st_q.masks)) else $error("mask changed");
  chk_alter_rearms: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ14]
    clk_en && is_alter && !take |=> st_q.en) else $error("enable not restored");
  chk_no_branch_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ12]
    clk_en && inst_end && !(any_prod && st_q.en) |=> !fetch_redirect)
    else $error("branch without cause");
  chk_flag40_or: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ22]
    flag_branch_reg[40] == |flag_branch_reg[39:37]) else $error("flag 40 wrong");

  // a low clock enable must freeze every stored field, pulses included
  chk_freeze_holds: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ2]
    !clk_en |=> $stable(st_q)) else $error("state moved while frozen");

  // the interval timer sets its flag without any instruction
  chk_timer_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ15]
    clk_en && timer_event |=> st_q.flags[DFBU_TIMER_IX]) else $error("timer flag lost");

  // a failed masked-key search leaves the no-match flag set
  chk_nomatch_sets: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ4]
    clk_en && inst_end && is_search(inst_op) && search_nomatch && cond_permit
    |=> st_q.flags[DFBU_NOMATCH_IX]) else $error("no-match flag not set");

  // without a permissive control bit and outside instruction end only the timer may touch the flags
  chk_gate_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ6]
    clk_en && !cond_permit && !timer_event && !inst_end
    |=> st_q.flags == $past(st_q.flags)) else $error("gated event set a flag");

  // no product set means no branch, whatever the free flags hold
  chk_free_no_branch: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ18]
    clk_en && inst_end && !any_prod |=> !ret_wr) else $error("branch without product");

  // a non-no-op start clears the free flags it may set, unless set again
  chk_free_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ17]
    clk_en && inst_start && !inst_noop && free_may_set[0] && !free_event[0]
    |=> !st_q.free[0]) else $error("free flag not cleared");

  // unassigned positions read as zero; free flags have no mask or product
  chk_spare_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ2] [RQ16]
    flag_branch_reg[2:0] == 3'h0 && flag_branch_reg[18:16] == 3'h0 &&
    flag_branch_reg[34:32] == 3'h0 && flag_branch_reg[50:48] == 3'h0 &&
    flag_branch_reg[63:56] == 8'h00) else $error("spare bits not zero");

  // the redirect is a single pulse because the taken branch drops enable
  chk_redirect_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RQ13]
    clk_en && fetch_redirect |=> !fetch_redirect) else $error("redirect held");
endmodule
`default_nettype wire
